// ==== adcs_defs.svh ====
// adcs_defs.svh: offsets, field positions and timing counts of the
// converter sequencer.
// assumes: included by bare name from the package and design files.
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

// register indices; byte address is four times the index
`define ADCS_IDX_CR1 6'h34
`define ADCS_IDX_CR2 6'h35
`define ADCS_IDX_RESL 6'h36
`define ADCS_IDX_RESH 6'h37
`define ADCS_ADDR_W 8

// control_reg_two fields
`define ADCS_CR2_DONE 7
`define ADCS_CR2_BUSY 6
`define ADCS_CR2_ACK_HI 2
`define ADCS_CR2_ACK_LO 0

// conversion time: 39 gear periods times two to the code
`define ADCS_BASE_CYC 11'h027
`define ADCS_ACK_MAX 3'h5
`define ADCS_CNT_W 11
`define ADCS_RES_W 10

// successive approximation: one bit every 3 counts
`define ADCS_STEP 3
`define ADCS_SET_OFS 4
`define ADCS_DEC_OFS 1

`endif

// ==== adcs_pkg.sv ====
// adcs_pkg.sv: types shared by the converter sequencer files.
// assumes: adcs_defs.svh is on the include path.
`include "adcs_defs.svh"

package adcs_pkg;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_RSVD = 2'h2,
    MODE_REPEAT = 2'h3
  } adcs_mode_e;

  typedef enum logic {
    ST_IDLE = 1'h0,
    ST_RUN = 1'h1
  } adcs_state_e;

  // control_reg_one layout, msb first
  typedef struct packed {
    logic start;
    adcs_mode_e mode;
    logic ain_en;
    logic [3:0] chan;
  } adcs_ctrl_s;

  typedef struct packed {
    logic kick;
    logic abort;
    logic [2:0] ack;
  } adcs_conv_req_s;

  typedef struct packed {
    logic done;
    logic [`ADCS_RES_W-1:0] result;
  } adcs_conv_rsp_s;

  typedef struct packed {
    adcs_state_e st;
    logic [`ADCS_CNT_W-1:0] cnt;
    logic [`ADCS_RES_W-1:0] sar;
    logic done;
  } adcs_sar_s;

  typedef struct packed {
    adcs_ctrl_s ctrl;
    logic [2:0] ack;
    logic done_flag;
    logic busy_flag;
    logic [`ADCS_RES_W-1:0] res;
    logic low_pending;
    logic irq;
    logic ref_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic comp_s1;
    logic comp_s2;
  } adcs_top_s;

endpackage : adcs_pkg

// ==== adcs_sar_timer.sv ====
// adcs_sar_timer.sv: conversion timer and successive-approximation
// register.
// assumes: synchronised comparator level; kick and abort from the
// sequencer on the same clock.
`include "adcs_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module adcs_sar_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire adcs_pkg::adcs_conv_req_s req,
  input wire logic comp_sync,
  output var adcs_pkg::adcs_conv_rsp_s rsp,
  output logic [`ADCS_RES_W-1:0] dac_code
);

  adcs_pkg::adcs_sar_s r_reg;
  adcs_pkg::adcs_sar_s r_next;
  logic [`ADCS_RES_W-1:0] set_hit;
  logic [`ADCS_RES_W-1:0] dec_hit;
  logic [2:0] ack_eff;

  // trial bit set, then decided 3 counts later: room for the
  // two-flop comparator synchroniser
  genvar k;
  generate
    for (k = 0; k < `ADCS_RES_W; k = k + 1) begin : g_bit
      assign set_hit[k] = (r_reg.cnt ==
        `ADCS_CNT_W'(`ADCS_STEP * k + `ADCS_SET_OFS));
      assign dec_hit[k] = (r_reg.cnt ==
        `ADCS_CNT_W'(`ADCS_STEP * k + `ADCS_DEC_OFS));
    end
  endgenerate

  // reserved codes run the longest time
  assign ack_eff = (req.ack > `ADCS_ACK_MAX) ? `ADCS_ACK_MAX : req.ack;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (req.abort) begin
      r_next.st = adcs_pkg::ST_IDLE;
      r_next.cnt = '0;
      r_next.sar = '0;
    end else if (req.kick) begin
      r_next.st = adcs_pkg::ST_RUN;
      r_next.cnt = (`ADCS_BASE_CYC << ack_eff) - `ADCS_CNT_W'(1);
      r_next.sar = '0;
    end else begin
      unique case (r_reg.st)
        adcs_pkg::ST_IDLE: begin
          r_next.cnt = r_reg.cnt;
        end
        adcs_pkg::ST_RUN: begin
          r_next.sar = (r_reg.sar | set_hit) &
                       ~(dec_hit & {`ADCS_RES_W{~comp_sync}});
          if (r_reg.cnt == '0) begin
            r_next.st = adcs_pkg::ST_IDLE;
            r_next.done = 1'b1;
          end else begin
            r_next.cnt = r_reg.cnt - `ADCS_CNT_W'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rsp.done = r_reg.done;
  assign rsp.result = r_reg.sar;
  assign dac_code = r_reg.sar;

endmodule : adcs_sar_timer

`default_nettype wire

// ==== adcs_top.sv ====
// adcs_top.sv: conversion sequencer with its APB register file.
// assumes: APB master on pclk; comparator level from the analog core
// arrives asynchronously; low_power_req comes from pclk logic.
//
// Behaviour
// - mode 01 plus start converts once
// - start bit clears itself, reads zero
// - busy set at start, cleared at end/stop
// - completion stores result, sets done, interrupts
// - reading high result clears done flag
// - mode 11 plus start converts continuously
// - repeat restarts right after each completion
// - completion between low and high read discarded
// - mode 00 stops at once, nothing stored
// - mode 00 zeroes flags and results
// - restart before high read clears done
// - low power aborts and zeroes control_reg_one, results
// - low power disconnects the reference
// - result is 10-bit unsigned code
// - time code picks 39 to 1248 periods
// - result split low byte, high two bits
`include "adcs_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module adcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADCS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comp_in,
  input wire logic low_power_req,
  output logic [`ADCS_RES_W-1:0] dac_code,
  output logic [3:0] channel_select,
  output logic analog_input_enable,
  output logic reference_voltage_en,
  output logic conv_done_irq
);

  adcs_pkg::adcs_top_s r_reg;
  adcs_pkg::adcs_top_s r_next;
  adcs_pkg::adcs_conv_req_s req;
  adcs_pkg::adcs_conv_rsp_s rsp;

  logic access;
  logic finish;
  logic wr_ok;
  logic rd_ok;
  logic hit_cr1;
  logic hit_cr2;
  logic hit_resl;
  logic hit_resh;
  logic hit;
  logic [31:0] rd_data;
  adcs_pkg::adcs_ctrl_s wr_ctrl;
  logic running_mode;

  assign hit_cr1 = (paddr == {`ADCS_IDX_CR1, 2'h0});
  assign hit_cr2 = (paddr == {`ADCS_IDX_CR2, 2'h0});
  assign hit_resl = (paddr == {`ADCS_IDX_RESL, 2'h0});
  assign hit_resh = (paddr == {`ADCS_IDX_RESH, 2'h0});
  assign hit = hit_cr1 | hit_cr2 | hit_resl | hit_resh;

  // one wait state so that prdata and pready come from flops
  assign access = psel & penable;
  assign finish = access & r_reg.pready;
  // register data sits in byte lane 0
  assign wr_ok = finish & pwrite & pstrb[0] & hit;
  assign rd_ok = finish & ~pwrite & hit;
  assign wr_ctrl = adcs_pkg::adcs_ctrl_s'(pwdata[7:0]);

  assign running_mode = (r_reg.ctrl.mode == adcs_pkg::MODE_SINGLE) |
                        (r_reg.ctrl.mode == adcs_pkg::MODE_REPEAT);

  always_comb begin
    rd_data = '0;
    if (hit_cr1) begin
      rd_data[7:0] = r_reg.ctrl;
    end else if (hit_cr2) begin
      rd_data[`ADCS_CR2_DONE] = r_reg.done_flag;
      rd_data[`ADCS_CR2_BUSY] = r_reg.busy_flag;
      rd_data[`ADCS_CR2_ACK_HI:`ADCS_CR2_ACK_LO] = r_reg.ack;
    end else if (hit_resl) begin
      rd_data[7:0] = r_reg.res[7:0];
    end else if (hit_resh) begin
      // upper six bits of the byte read as zero
      rd_data[1:0] = r_reg.res[9:8];
    end
  end

  always_comb begin
    r_next = r_reg;
    req = '0;
    req.ack = r_reg.ack;
    r_next.irq = 1'b0;
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    r_next.comp_s1 = comp_in;
    r_next.comp_s2 = r_reg.comp_s1;

    // bus answer, one cycle into the access phase
    if (access & ~r_reg.pready) begin
      r_next.pready = 1'b1;
      r_next.prdata = rd_data;
      r_next.pslverr = ~hit;
    end

    // read side effects
    if (rd_ok & hit_resl) begin
      r_next.low_pending = 1'b1;
    end
    if (rd_ok & hit_resh) begin
      r_next.done_flag = 1'b0;
      r_next.low_pending = 1'b0;
    end

    // completion; a set here wins over the read clear above
    if (rsp.done) begin
      if (r_reg.ctrl.mode == adcs_pkg::MODE_REPEAT) begin
        req.kick = 1'b1;
      end else begin
        r_next.busy_flag = 1'b0;
        r_next.ref_en = 1'b0;
      end
      // a half-read pair is never overwritten
      if (r_next.low_pending) begin
        r_next.res = r_reg.res;
      end else begin
        r_next.res = rsp.result;
        r_next.done_flag = 1'b1;
        r_next.irq = 1'b1;
      end
    end

    // register writes
    if (wr_ok & hit_cr1) begin
      r_next.ctrl = wr_ctrl;
      if (wr_ctrl.mode == adcs_pkg::MODE_OFF) begin
        // forced stop outranks a completion in the same cycle
        req.kick = 1'b0;
        req.abort = 1'b1;
        r_next.busy_flag = 1'b0;
        r_next.done_flag = 1'b0;
        r_next.res = '0;
        r_next.irq = 1'b0;
        r_next.low_pending = 1'b0;
        r_next.ref_en = 1'b0;
      end
    end
    if (wr_ok & hit_cr2) begin
      r_next.ack = pwdata[`ADCS_CR2_ACK_HI:`ADCS_CR2_ACK_LO];
    end

    // start trigger, seen one cycle after it was written
    if (r_reg.ctrl.start) begin
      r_next.ctrl.start = 1'b0;
      // start while busy is ignored: software must not do it
      if (running_mode & ~r_reg.busy_flag & ~req.abort) begin
        req.kick = 1'b1;
        r_next.busy_flag = 1'b1;
        r_next.ref_en = 1'b1;
        // old result stays until the new one lands
        r_next.done_flag = 1'b0;
      end
    end

    // low-power entry clears everything but the time code and stops the converter
    if (low_power_req) begin
      req.kick = 1'b0;
      req.abort = 1'b1;
      r_next.ctrl = '0;
      r_next.busy_flag = 1'b0;
      r_next.done_flag = 1'b0;
      r_next.res = '0;
      r_next.irq = 1'b0;
      r_next.low_pending = 1'b0;
      r_next.ref_en = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // comparator only reaches the sar through the second flop
  adcs_sar_timer u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .req(req),
    .comp_sync(r_reg.comp_s2),
    .rsp(rsp),
    .dac_code(dac_code)
  );

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign channel_select = r_reg.ctrl.chan;
  assign analog_input_enable = r_reg.ctrl.ain_en;
  assign reference_voltage_en = r_reg.ref_en;
  assign conv_done_irq = r_reg.irq;

endmodule : adcs_top

`default_nettype wire

// ==== adcs_ana_model.sv ====
// adcs_ana_model.sv: ideal comparator standing for the analog side.
// assumes: vin comes from the bench and is held through a conversion.
`timescale 1ns/100ps
`default_nettype none
module adcs_ana_model (
  input wire logic [9:0] dac_code,
  input wire logic [9:0] vin,
  input wire logic ref_en,
  output logic comp_in
);
  logic flip = 1'h0;
  // without reference the level is noise, never a held answer
  always #7 flip = ~flip;
  assign comp_in = ref_en ? vin >= dac_code : flip;
endmodule : adcs_ana_model
`default_nettype wire

// ==== adcs_top_props.sv ====
// adcs_top_props.sv: port checks of adcs_top.
// assumes: bound to adcs_top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module adcs_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic low_power_req,
  input wire logic analog_input_enable,
  input wire logic reference_voltage_en,
  input wire logic conv_done_irq
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic stop_w;
  assign stop_w = psel && penable && pready && pwrite && paddr == 8'hD0
    && pstrb[0] && pwdata[6:5] == 2'h0;
  // any bus access may be a stop, so only quiet stretches count
  sequence s_quiet;
    (!low_power_req && !psel) [*8];
  endsequence
  property p_irq; conv_done_irq |=> !conv_done_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq wide");
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready wide");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_dec;
    pready |-> pslverr == !(paddr inside {8'hD0, 8'hD4, 8'hD8, 8'hDC});
  endproperty
  a_dec: assert property (p_dec) else $error("bad pslverr");
  property p_lp;
    low_power_req |=> !reference_voltage_en && !analog_input_enable;
  endproperty
  a_lp: assert property (p_lp) else $error("lp not cleared");
  property p_stop;
    stop_w |=> !reference_voltage_en && !conv_done_irq;
  endproperty
  a_stop: assert property (p_stop) else $error("stop late");
  property p_src; conv_done_irq |-> $past(reference_voltage_en); endproperty
  a_src: assert property (p_src) else $error("irq no run");
  property p_min;
    $rose(reference_voltage_en) ##0 s_quiet |-> reference_voltage_en;
  endproperty
  a_min: assert property (p_min) else $error("run short");
endmodule : adcs_top_props
bind adcs_top adcs_top_props i_adcs_top_props (.*);
`default_nettype wire

// ==== adcs_tb.sv ====
// adcs_tb.sv: directed bench for adcs_top with an ideal comparator.
// assumes: model and bound checker compiled before it.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, low_power_req = 1'h0, pready, pslverr, comp_in;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0] vin = 10'h000, dac_code;
  logic [3:0] channel_select;
  logic er, ain, ref_en, irq;
  int fails = 0, n_tests = 0, d;
  time t0;
  adcs_top i_adcs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .comp_in,
    .low_power_req, .dac_code, .channel_select, .analog_input_enable(ain),
    .reference_voltage_en(ref_en), .conv_done_irq(irq));
  adcs_ana_model i_adcs_ana_model (.dac_code, .vin, .ref_en, .comp_in);
  task automatic complete_run(input logic hung);
    if (hung) fails++;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string s, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 9);
    if (k >= 9) complete_run(1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rdchk
  task automatic wirq;
    int k = 0;
    while (irq !== 1'h1 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 3000) complete_run(1'h1);
  endtask : wirq
  task automatic t_regs;
    for (int i = 0; i < 4; i++) rdchk(8'hD0 + 8'(4 * i), 32'h0);
    apb(1'h0, 8'hE0, 32'h0);
    chk("pslverr", 32'h1, er);
    $display("registers done");
  endtask : t_regs
  task automatic t_single;
    for (int c = 0; c < 6; c++) begin
      vin <= 10'(c * 170 + 5);
      apb(1'h1, 8'hD4, 32'(c));
      apb(1'h1, 8'hD0, 32'hB3);
      t0 = $time;
      rdchk(8'hD0, 32'h33);
      chk("channel_select", 32'h3, channel_select);
      rdchk(8'hD4, 32'h40 | c);
      wirq();
      d = int'(($time - t0) / 10);
      chk("conv_time", 32'h1, d >= (39 << c) && d <= (39 << c) + 4);
      rdchk(8'hD4, 32'h80 | c);
      rdchk(8'hD8, 32'(vin[7:0]));
      rdchk(8'hDC, 32'(vin[9:8]));
      rdchk(8'hD4, 32'(c));
    end
    $display("single done");
  endtask : t_single
  task automatic t_restart;
    vin <= 10'h123;
    apb(1'h1, 8'hD4, 32'h0);
    apb(1'h1, 8'hD0, 32'hB3);
    wirq();
    vin <= 10'h321;
    apb(1'h1, 8'hD0, 32'hB3);
    rdchk(8'hD4, 32'h40);
    rdchk(8'hDC, 32'h1);
    wirq();
    rdchk(8'hD8, 32'h21);
    rdchk(8'hDC, 32'h3);
    $display("restart done");
  endtask : t_restart
  task automatic t_repeat;
    vin <= 10'h2A5;
    apb(1'h1, 8'hD4, 32'h1);
    apb(1'h1, 8'hD0, 32'hF3);
    wirq();
    t0 = $time;
    vin <= 10'h15A;
    @(posedge pclk);
    wirq();
    d = int'(($time - t0) / 10);
    chk("period", 32'h1, d >= 78 && d <= 82);
    rdchk(8'hD8, 32'h5A);
    vin <= 10'h0F0;
    d = 0;
    repeat (100) begin
      @(posedge pclk);
      if (irq === 1'h1) d++;
    end
    chk("irq_count", 32'h0, d);
    rdchk(8'hDC, 32'h1);
    apb(1'h1, 8'hD0, 32'h13);
    rdchk(8'hD4, 32'h1);
    chk("dac_code", 32'h0, dac_code);
    rdchk(8'hD8, 32'h0);
    rdchk(8'hDC, 32'h0);
    $display("repeat done");
  endtask : t_repeat
  task automatic t_low;
    apb(1'h1, 8'hD4, 32'h5);
    apb(1'h1, 8'hD0, 32'hB3);
    repeat (10) @(posedge pclk);
    low_power_req <= 1'h1;
    repeat (2) @(posedge pclk);
    chk("ref_en", 32'h0, ref_en);
    chk("ain", 32'h0, ain);
    low_power_req <= 1'h0;
    rdchk(8'hD0, 32'h0);
    rdchk(8'hD4, 32'h5);
    // controls were wiped, so program them again before a new start
    apb(1'h1, 8'hD0, 32'hB3);
    rdchk(8'hD4, 32'h45);
    wirq();
    rdchk(8'hD4, 32'h85);
    $display("low power done");
  endtask : t_low
  initial forever #5 pclk = ~pclk;
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    t_single();
    t_restart();
    t_repeat();
    t_low();
    complete_run(1'h0);
  end
endmodule : testbench
`default_nettype wire
